// *** hdl/pcl_pkg.sv ***
// constants and types shared by both ends of the parallel configuration load link
//
// Functional notes
// [R01] ratio r: 1 plain, 4 security, 8 decompression
// [R02] host clocks r cycles per data word
// [R03] host adds r-1 clocks after last word
// [R04] user mode: all high; request low restarts
// [R05] status held low through power-on delay
// [R06] load_complete low until all words received
// [R07] two falling edges after load_complete start init
// [R08] clock ignored after load; host parks it
// [R09] host pauses clock low, data before rise
// [R10] 8-bit uses 7..0, 16-bit uses 15..0
// [R11] loaded option bit drives init_done low
// [R12] host holds request low at least 2 us
// [R13] status and load_complete low within 600 ns
// [R14] status low 268 us, released after request
// [R15] host waits 2 us after status rises
// [R16] device captures word on clock rising edge
// [R17] oscillator init lasts 175 to 437 us
// [R18] user clock: 4 periods then 8576 cycles
// [R19] init clock: oscillator, user or config clock; the config clock choice goes straight to user mode without counting clocks
// [R20] one word per r-cycle group, others ignored
package pcl_pkg;
	localparam int CLK_MHZ          = 125;
	localparam int CFG_LOW_NS       = 2000;
	localparam int CFG_LOW_CYC      = (CFG_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int ST2CK_NS         = 2000;
	localparam int ST2CK_CYC        = (ST2CK_NS * CLK_MHZ + 999) / 1000;
	localparam int STATUS_LOW_US    = 268;
	localparam int STATUS_LOW_CYC   = STATUS_LOW_US * CLK_MHZ;
	localparam int INIT_OSC_US      = 175;
	localparam int INIT_OSC_CYC     = INIT_OSC_US * CLK_MHZ;
	localparam int CD2CU_PERIODS    = 4;
	localparam int MAX_CFG_CLK_MHZ  = 125;
	localparam int CD2CU_CYC        = (CD2CU_PERIODS * CLK_MHZ + MAX_CFG_CLK_MHZ - 1) / MAX_CFG_CLK_MHZ;
	localparam int USER_INIT_CYCLES = 8576;
	localparam int POR_CYC_DEF      = 1000;
	localparam int LOAD_WORDS_DEF   = 16;
	localparam int CLK_HALF_DEF     = 8;
	localparam logic [3:0] RATIO_PLAIN  = 4'h1;
	localparam logic [3:0] RATIO_SECURE = 4'h4;
	localparam logic [3:0] RATIO_DECOMP = 4'h8;
	localparam int INIT_OPT_BIT     = 0;
	// host register map, byte addresses
	localparam logic [3:0] REG_CTRL  = 4'h0;
	localparam logic [3:0] REG_STAT  = 4'h4;
	localparam logic [3:0] REG_DATA  = 4'h8;
	localparam logic [3:0] REG_WORDS = 4'hC;
	localparam int CTRL_START_BIT  = 0;
	localparam int CTRL_DECOMP_BIT = 1;
	localparam int CTRL_SEC_BIT    = 2;
	localparam int CTRL_HOLD_BIT   = 3;
	localparam int STAT_BUSY_BIT   = 0;
	localparam int STAT_DONE_BIT   = 1;
	localparam int STAT_STATUS_BIT = 2;
	localparam int STAT_LC_BIT     = 3;
	localparam int STAT_FULL_BIT   = 4;

	typedef enum logic [1:0] {PCL_W8, PCL_W16, PCL_W32} pcl_width_t;
	typedef enum logic [1:0] {PCL_INIT_OSC, PCL_INIT_USER, PCL_INIT_CFGCLK} pcl_init_src_t;

	function automatic logic [3:0] pcl_ratio(input logic decomp, input logic secure);
		if (decomp)
			return RATIO_DECOMP;
		else if (secure)
			return RATIO_SECURE;
		else
			return RATIO_PLAIN;
	endfunction
endpackage

// *** hdl/pcl_link_if.sv ***
// link wires between configuration host and device, open-drain lines resolved here
`timescale 1ns/10ps
interface pcl_link_if;
	logic        config_request_n;
	logic        config_clock;
	logic [31:0] data;
	logic        dev_status_oe;
	logic        host_status_oe;
	logic        load_complete_oe;
	logic        status_n;
	logic        load_complete;

	// open-drain lines pulled high unless someone pulls low
	assign status_n      = !(dev_status_oe || host_status_oe);
	assign load_complete = !load_complete_oe;

	modport dev (
		input  config_request_n,
		input  config_clock,
		input  data,
		input  status_n,
		output dev_status_oe,
		output load_complete_oe
	);
	modport host (
		output config_request_n,
		output config_clock,
		output data,
		output host_status_oe,
		input  status_n,
		input  load_complete
	);
endinterface

// *** hdl/pcl_sync.sv ***
// two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/10ps
module pcl_sync #(
	parameter int W = 1
) (
	input  wire logic         ref_clk_in, // system clock
	input  wire logic         rst_in,     // async reset, active high
	input  wire logic [W-1:0] d_in,       // asynchronous input
	output logic      [W-1:0] q_out       // synchronised output
);
	logic [W-1:0] meta_r;

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			meta_r <= '0;
			q_out  <= '0;
		end else begin
			meta_r <= d_in;
			q_out  <= meta_r;
		end
	end
endmodule

// *** hdl/pcl_device.sv ***
// device end: loads configuration words from the parallel link and runs initialization
//
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/10ps
module pcl_device
	import pcl_pkg::*;
#(
	parameter int POR_CYC        = pcl_pkg::POR_CYC_DEF,
	parameter int STATUS_LOW_CYC = pcl_pkg::STATUS_LOW_CYC,
	parameter int INIT_OSC_CYC   = pcl_pkg::INIT_OSC_CYC,
	parameter int USER_INIT_CYC  = pcl_pkg::USER_INIT_CYCLES,
	parameter int LOAD_WORDS     = pcl_pkg::LOAD_WORDS_DEF
) (
	input  wire logic                   ref_clk_in,         // system clock
	input  wire logic                   rst_in,             // async reset, active high
	pcl_link_if.dev                     link,               // link to host
	input  wire pcl_pkg::pcl_width_t    width_in,           // load width
	input  wire logic                   decomp_in,          // decompression on
	input  wire logic                   sec_in,             // security on
	input  wire pcl_pkg::pcl_init_src_t init_src_in,        // initialization clock source
	input  wire logic                   user_init_clock_in, // user-supplied init clock
	output logic [31:0]                 word_out,           // last captured word
	output logic                        word_valid_out,     // one-cycle pulse per word
	output logic                        user_mode_out,      // device in user mode
	output logic                        init_done_out       // low from the option word until user mode, only when the option bit is set
);
	import pcl_pkg::*;

	typedef enum {
		ST_POR, ST_CLEAR, ST_STATUS, ST_WAIT_ST, ST_LOAD, ST_EDGES, ST_INIT, ST_USER
	} pcl_dev_state_t;

	////////////////////////////////////////////////////////////////////////////////
	// input synchronisation and edge detection

	logic [35:0] sync_s;
	logic [31:0] data_s;
	logic        req_s;
	logic        clk_s;
	logic        status_s;
	logic        uclk_s;
	logic        clk_d_r;
	logic        uclk_d_r;
	logic        clk_rise;
	logic        clk_fall;
	logic        uclk_rise;

	pcl_sync #(.W(36)) u_sync (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.d_in       ({link.data, link.config_request_n, link.config_clock, link.status_n, user_init_clock_in}),
		.q_out      (sync_s)
	);

	assign data_s   = sync_s[35:4];
	assign req_s    = sync_s[3];
	assign clk_s    = sync_s[2];
	assign status_s = sync_s[1];
	assign uclk_s   = sync_s[0];

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			clk_d_r  <= 1'b0;
			uclk_d_r <= 1'b0;
		end else begin
			clk_d_r  <= clk_s;
			uclk_d_r <= uclk_s;
		end
	end

	assign clk_rise  = clk_s && !clk_d_r;
	assign clk_fall  = !clk_s && clk_d_r;
	assign uclk_rise = uclk_s && !uclk_d_r;

	////////////////////////////////////////////////////////////////////////////////
	// sequence control

	pcl_dev_state_t state_r;
	logic [31:0]    cnt_r;
	logic [3:0]     ratio_r;
	logic [3:0]     phase_r;
	logic [31:0]    words_r;
	logic           pre_done_r;
	logic           group_end;
	logic           last_group;

	assign group_end  = (phase_r == ratio_r - 4'h1);
	assign last_group = (words_r == 32'(LOAD_WORDS - 1));

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_r    <= ST_POR;
			cnt_r      <= '0;
			ratio_r    <= RATIO_PLAIN;
			phase_r    <= '0;
			words_r    <= '0;
			pre_done_r <= 1'b0;
		end else if (!req_s && state_r != ST_POR) begin
			state_r <= ST_CLEAR;                                                   // [R04]
			cnt_r   <= '0;
		end else begin
			case (state_r)
				ST_POR: begin
					cnt_r <= cnt_r + 32'h1;
					if (cnt_r >= 32'(POR_CYC - 1)) begin                           // [R05]
						state_r <= ST_WAIT_ST;
						cnt_r   <= '0;
					end
				end
				ST_CLEAR: begin
					state_r <= ST_STATUS;
					cnt_r   <= '0;
				end
				ST_STATUS: begin
					cnt_r <= cnt_r + 32'h1;
					if (cnt_r >= 32'(STATUS_LOW_CYC - 1))                          // [R14]
						state_r <= ST_WAIT_ST;
				end
				ST_WAIT_ST: begin
					// wait while the host holds the status line low
					if (status_s) begin
						state_r <= ST_LOAD;
						ratio_r <= pcl_ratio(decomp_in, sec_in);                   // [R01]
						phase_r <= '0;
						words_r <= '0;
					end
				end
				ST_LOAD: begin
					if (clk_rise) begin                                            // [R02]
						phase_r <= group_end ? 4'h0 : phase_r + 4'h1;              // [R20]
						if (group_end) begin
							words_r <= words_r + 32'h1;
							if (last_group) begin
								state_r <= ST_EDGES;                               // [R06]
								cnt_r   <= '0;
							end
						end
					end
				end
				ST_EDGES: begin
					if (clk_fall) begin
						cnt_r <= cnt_r + 32'h1;
						// the last word's pulse and the r-1 tail pulses fall first
						if (cnt_r == 32'(ratio_r) + 32'h1) begin                   // [R03] [R07]
							state_r    <= ST_INIT;
							cnt_r      <= '0;
							pre_done_r <= 1'b0;
						end
					end
				end
				ST_INIT: begin
					case (init_src_in)                                             // [R19]
						PCL_INIT_OSC: begin
							cnt_r <= cnt_r + 32'h1;
							if (cnt_r >= 32'(INIT_OSC_CYC - 1))                    // [R17]
								state_r <= ST_USER;
						end
						PCL_INIT_USER: begin
							if (!pre_done_r) begin
								cnt_r <= cnt_r + 32'h1;
								if (cnt_r >= 32'(CD2CU_CYC - 1)) begin             // [R18]
									pre_done_r <= 1'b1;
									cnt_r      <= '0;
								end
							end else if (uclk_rise) begin
								cnt_r <= cnt_r + 32'h1;
								if (cnt_r >= 32'(USER_INIT_CYC - 1))               // [R18]
									state_r <= ST_USER;
							end
						end
						default: state_r <= ST_USER;
					endcase
				end
				ST_USER: begin
					// config clock ignored from here on
					state_r <= ST_USER;                                            // [R08]
				end
				default: state_r <= ST_POR;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// word capture

	logic [31:0] mask;
	logic        opt_r;

	always_comb begin
		case (width_in)
			PCL_W8:  mask = 32'h0000_00FF;                                         // [R10]
			PCL_W16: mask = 32'h0000_FFFF;                                         // [R10]
			default: mask = 32'hFFFF_FFFF;
		endcase
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			word_out       <= '0;
			word_valid_out <= 1'b0;
			opt_r          <= 1'b0;
		end else begin
			word_valid_out <= 1'b0;
			if (state_r == ST_CLEAR)
				opt_r <= 1'b0;
			if (state_r == ST_LOAD && clk_rise && phase_r == 4'h0) begin           // [R16] [R20]
				word_out       <= data_s & mask;
				word_valid_out <= 1'b1;
				if (words_r == 32'h0)
					opt_r <= data_s[INIT_OPT_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// line drivers

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			link.dev_status_oe    <= 1'b1;
			link.load_complete_oe <= 1'b1;
			user_mode_out         <= 1'b0;
			init_done_out         <= 1'b1;
		end else begin
			link.dev_status_oe <= (state_r == ST_POR || state_r == ST_CLEAR
				|| state_r == ST_STATUS || !req_s);                                // [R05] [R13] [R14]
			link.load_complete_oe <= (state_r != ST_EDGES && state_r != ST_INIT
				&& state_r != ST_USER) || !req_s;                                  // [R06] [R13]
			user_mode_out <= (state_r == ST_USER);                                 // [R04]
			init_done_out <= !opt_r || state_r == ST_USER;                         // [R11]
		end
	end
endmodule

// *** hdl/pcl_host.sv ***
// host end: drives the configuration link under Avalon-MM register control
`timescale 1ns/10ps
module pcl_host
	import pcl_pkg::*;
#(
	parameter int CLK_HALF    = pcl_pkg::CLK_HALF_DEF,
	parameter int CFG_LOW_CYC = pcl_pkg::CFG_LOW_CYC,
	parameter int ST2CK_CYC   = pcl_pkg::ST2CK_CYC
) (
	input  wire logic        ref_clk_in,          // system clock
	input  wire logic        rst_in,              // async reset, active high
	input  wire logic [3:0]  avs_address,         // byte address
	input  wire logic        avs_read,            // read request
	input  wire logic        avs_write,           // write request
	input  wire logic [31:0] avs_writedata,       // write data
	output logic      [31:0] avs_readdata,        // read data
	output logic             avs_waitrequest,     // stall
	pcl_link_if.host         link                 // link to device
);
	import pcl_pkg::*;

	typedef enum {
		H_IDLE, H_REQ, H_WAIT_ST, H_GAP, H_WORDS, H_TAIL, H_WAIT_LC, H_EDGES, H_DONE
	} pcl_host_state_t;

	////////////////////////////////////////////////////////////////////////////////
	// registers

	logic [1:0]      sync_s;
	logic            status_s;
	logic            lc_s;
	pcl_host_state_t state_r;
	logic            decomp_r;
	logic            sec_r;
	logic            start_r;
	logic [15:0]     total_r;
	logic [31:0]     word_r;
	logic            full_r;
	logic            take_word;
	logic            clk_idle;
	logic [3:0]      pulses_r;
	logic [3:0]      ratio;
	logic            acc;

	pcl_sync #(.W(2)) u_sync (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.d_in       ({link.status_n, link.load_complete}),
		.q_out      (sync_s)
	);

	assign status_s = sync_s[1];
	assign lc_s     = sync_s[0];
	assign ratio    = pcl_ratio(decomp_r, sec_r);                                  // [R01]
	assign acc      = !avs_waitrequest && (avs_read || avs_write);

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			avs_waitrequest     <= 1'b1;
			avs_readdata        <= '0;
			decomp_r            <= 1'b0;
			sec_r               <= 1'b0;
			link.host_status_oe <= 1'b0;
			start_r             <= 1'b0;
			total_r             <= 16'h0001;
			word_r              <= '0;
			full_r              <= 1'b0;
		end else begin
			avs_waitrequest <= 1'b1;
			start_r         <= 1'b0;
			// data writes stall while the previous word is still unsent
			if ((avs_read || avs_write) && avs_waitrequest
				&& !(avs_write && avs_address == REG_DATA && full_r)) begin
				avs_waitrequest <= 1'b0;
				case (avs_address)
					REG_CTRL:  avs_readdata <= {28'h0, link.host_status_oe, sec_r, decomp_r, 1'b0};
					REG_STAT:  avs_readdata <= {27'h0, full_r, lc_s, status_s,
						state_r == H_DONE, state_r != H_IDLE && state_r != H_DONE};
					REG_WORDS: avs_readdata <= {16'h0, total_r};
					default:   avs_readdata <= '0;
				endcase
			end
			if (take_word)
				full_r <= 1'b0;
			if (acc && avs_write) begin
				case (avs_address)
					REG_CTRL: begin
						start_r             <= avs_writedata[CTRL_START_BIT];
						decomp_r            <= avs_writedata[CTRL_DECOMP_BIT];
						sec_r               <= avs_writedata[CTRL_SEC_BIT];
						link.host_status_oe <= avs_writedata[CTRL_HOLD_BIT];
					end
					REG_DATA: begin
						word_r <= avs_writedata;
						full_r <= 1'b1;
					end
					REG_WORDS: total_r <= avs_writedata[15:0];
					default: total_r <= total_r;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// configuration clock engine: each pulse is low half then high half

	logic [15:0] half_r;

	assign clk_idle  = (pulses_r == 4'h0) && !link.config_clock;
	assign take_word = (state_r == H_WORDS) && clk_idle && full_r;

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pulses_r          <= '0;
			half_r            <= '0;
			link.config_clock <= 1'b0;
		end else if (take_word) begin
			pulses_r <= ratio;                                                     // [R02]
			half_r   <= '0;
		end else if (state_r == H_TAIL && clk_idle) begin
			pulses_r <= ratio - 4'h1;                                              // [R03]
			half_r   <= '0;
		end else if (state_r == H_WAIT_LC && clk_idle && lc_s) begin
			pulses_r <= 4'h2;                                                      // [R07]
			half_r   <= '0;
		end else if (pulses_r != 4'h0) begin
			half_r <= half_r + 16'h1;
			if (half_r == 16'(CLK_HALF - 1)) begin
				half_r            <= '0;
				link.config_clock <= !link.config_clock;
				if (link.config_clock)
					pulses_r <= pulses_r - 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// load sequence

	logic [15:0] cnt_r;
	logic [15:0] sent_r;

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_r               <= H_IDLE;
			cnt_r                 <= '0;
			sent_r                <= '0;
			link.config_request_n <= 1'b1;
			link.data             <= '0;
		end else begin
			case (state_r)
				H_IDLE, H_DONE: begin
					if (start_r) begin
						state_r               <= H_REQ;
						link.config_request_n <= 1'b0;                             // [R04]
						cnt_r                 <= '0;
					end
				end
				H_REQ: begin
					cnt_r <= cnt_r + 16'h1;
					if (cnt_r >= 16'(CFG_LOW_CYC - 1)) begin                       // [R12]
						link.config_request_n <= 1'b1;
						state_r               <= H_WAIT_ST;
					end
				end
				H_WAIT_ST: begin
					cnt_r <= '0;
					// skip the first cycle so the released line has settled
					if (status_s && cnt_r == 16'h0 && link.config_request_n)
						state_r <= H_GAP;
				end
				H_GAP: begin
					cnt_r <= cnt_r + 16'h1;
					if (cnt_r >= 16'(ST2CK_CYC - 1)) begin                         // [R15]
						state_r <= H_WORDS;
						sent_r  <= '0;
					end
				end
				H_WORDS: begin
					if (take_word) begin
						link.data <= word_r;                                       // [R09]
						sent_r    <= sent_r + 16'h1;
					end else if (sent_r == total_r && clk_idle) begin
						state_r <= H_TAIL;
					end
				end
				H_TAIL: begin
					if (clk_idle)
						state_r <= H_WAIT_LC;
				end
				H_WAIT_LC: begin
					if (clk_idle && lc_s)
						state_r <= H_EDGES;
				end
				H_EDGES: begin
					// clock parks low once the pulses run out
					if (clk_idle)
						state_r <= H_DONE;                                         // [R08]
				end
				default: state_r <= H_IDLE;
			endcase
		end
	end
endmodule

// *** test/pcl_link_monitor.sv ***
// assertions on the resolved wires of the configuration link
`timescale 1ns/10ps
module pcl_link_monitor #(
	parameter int CFG_LOW_CYC    = 10,
	parameter int ST2CK_CYC      = 4,
	parameter int STATUS_LOW_CYC = 50
) (
	input  wire logic        ref_clk_in,       // system clock
	input  wire logic        rst_in,           // async reset, active high
	input  wire logic        config_request_n, // request line
	input  wire logic        config_clock,     // link clock
	input  wire logic [31:0] data,             // link data
	input  wire logic        status_n,         // resolved status line
	input  wire logic        load_complete     // resolved load complete line
);
	int unsigned req_low_r;
	int unsigned st_low_r;
	int unsigned st_high_r;
	logic        seen_req_r;

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in)
			req_low_r <= 0;
		else if (!config_request_n)
			req_low_r <= req_low_r + 1;
		else
			req_low_r <= 0;
	end
	// status low time counted only after a request, not after power-on
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in)
			seen_req_r <= 1'b0;
		else if (!config_request_n)
			seen_req_r <= 1'b1;
	end
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in)
			st_low_r <= 0;
		else if (!config_request_n)
			st_low_r <= 0;
		else if (!status_n && seen_req_r)
			st_low_r <= st_low_r + 1;
	end
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in)
			st_high_r <= 0;
		else if (!status_n)
			st_high_r <= 0;
		else if (st_high_r < 1000)
			st_high_r <= st_high_r + 1;
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);

	sequence s_req_fall;
		$fell(config_request_n);
	endsequence
	sequence s_lines_low;
		!status_n && !load_complete;
	endsequence

	chk_req_pulls_low: assert property (s_req_fall |-> ##[1:75] s_lines_low)
		else $error("status or load complete not pulled low after request");
	chk_req_width: assert property ($rose(config_request_n) |-> req_low_r >= CFG_LOW_CYC)
		else $error("request low pulse too short");
	chk_status_min: assert property ($rose(status_n) && seen_req_r |-> st_low_r >= STATUS_LOW_CYC)
		else $error("status released too early");
	chk_status_max: assert property (st_low_r <= STATUS_LOW_CYC + 8)
		else $error("status held low too long");
	chk_clock_wait: assert property ($rose(config_clock) |-> st_high_r >= ST2CK_CYC)
		else $error("clock rose too soon after status");
	chk_clock_idle: assert property (!status_n |-> !config_clock)
		else $error("clock toggles while status low");
	chk_lc_holds: assert property (load_complete && config_request_n |=> load_complete)
		else $error("load complete dropped without request");
	chk_lc_low_cfg: assert property (!status_n [*4] |-> !load_complete)
		else $error("load complete high while status low");
	chk_data_hold: assert property (config_clock |-> $stable(data))
		else $error("data changed while clock high");
endmodule

// *** test/parallel_config_load_port_test.sv ***
// self-checking bench joining host and device ends of the configuration link
`timescale 1ns/10ps
module parallel_config_load_port_test;
	import pcl_pkg::*;
	localparam int N_WORDS = 4;
	localparam int L_CFG   = 10;
	localparam int L_ST2CK = 4;
	localparam int L_STLOW = 50;
	logic          ref_clk_in;
	logic          rst_in;
	logic [3:0]    avs_address;
	logic          avs_read;
	logic          avs_write;
	logic [31:0]   avs_writedata;
	logic [31:0]   avs_readdata;
	logic          avs_waitrequest;
	pcl_width_t    width_in;
	logic          decomp_in;
	logic          sec_in;
	pcl_init_src_t init_src_in;
	logic          user_init_clock_in;
	logic [31:0]   word_out;
	logic          word_valid_out;
	logic          user_mode_out;
	logic          init_done_out;
	int            n_fail;
	int            checks_done;
	logic [31:0]   got_q[$];

	pcl_link_if u_pcl_link_if ();
	pcl_host #(.CLK_HALF(4), .CFG_LOW_CYC(L_CFG), .ST2CK_CYC(L_ST2CK)) u_pcl_host (
		.ref_clk_in(ref_clk_in), .rst_in(rst_in), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .link(u_pcl_link_if.host));
	pcl_device #(.POR_CYC(20), .STATUS_LOW_CYC(L_STLOW), .INIT_OSC_CYC(40), .USER_INIT_CYC(16),
		.LOAD_WORDS(N_WORDS)) u_pcl_device (
		.ref_clk_in(ref_clk_in), .rst_in(rst_in), .link(u_pcl_link_if.dev), .width_in(width_in),
		.decomp_in(decomp_in), .sec_in(sec_in), .init_src_in(init_src_in),
		.user_init_clock_in(user_init_clock_in), .word_out(word_out), .word_valid_out(word_valid_out),
		.user_mode_out(user_mode_out), .init_done_out(init_done_out));
	pcl_link_monitor #(.CFG_LOW_CYC(L_CFG), .ST2CK_CYC(L_ST2CK), .STATUS_LOW_CYC(L_STLOW)) u_pcl_link_monitor (
		.ref_clk_in(ref_clk_in), .rst_in(rst_in), .config_request_n(u_pcl_link_if.config_request_n),
		.config_clock(u_pcl_link_if.config_clock), .data(u_pcl_link_if.data),
		.status_n(u_pcl_link_if.status_n), .load_complete(u_pcl_link_if.load_complete));

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge ref_clk_in) begin
		if (word_valid_out === 1'b1)
			got_q.push_back(word_out);
	end

	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one Avalon transfer, held until waitrequest is sampled low
	task automatic av_xfer(input logic wr, input logic [3:0] addr, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge ref_clk_in);
		avs_address <= addr;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= !wr;
		// only the watchdog ends a wait that never gets an answer
		do begin
			@(posedge ref_clk_in);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic t_reset();
		logic [31:0] rd;
		chk_val({31'h0, u_pcl_link_if.status_n}, 32'h0);
		chk_val({31'h0, u_pcl_link_if.load_complete}, 32'h0);
		av_xfer(1'b0, 4'h2, 32'h0, rd);
		chk_val(rd, 32'h0);
		av_xfer(1'b0, REG_WORDS, 32'h0, rd);
		chk_val(rd, 32'h1);
		for (int n = 0; n < 200 && u_pcl_link_if.status_n !== 1'b1; n++)
			@(posedge ref_clk_in);
		chk_val({31'h0, u_pcl_link_if.status_n}, 32'h1);
		$display("test reset done");
	endtask

	task automatic t_load(input logic dc, input logic sc, input pcl_width_t w, input pcl_init_src_t src,
		input logic [31:0] base, input int min_cyc);
		logic [31:0] rd;
		logic [31:0] mask;
		int          t;
		mask = (w == PCL_W8) ? 32'h000000FF : (w == PCL_W16) ? 32'h0000FFFF : 32'hFFFFFFFF;
		@(posedge ref_clk_in);
		width_in <= w;
		decomp_in <= dc;
		sec_in <= sc;
		init_src_in <= src;
		got_q.delete();
		av_xfer(1'b1, REG_WORDS, 32'(N_WORDS), rd);
		av_xfer(1'b1, REG_CTRL, {29'h0, sc, dc, 1'b1}, rd);
		for (int n = 0; n < 100 && u_pcl_link_if.load_complete !== 1'b0; n++)
			@(posedge ref_clk_in);
		// user mode drops one edge after load complete does
		@(posedge ref_clk_in);
		chk_val({31'h0, user_mode_out}, 32'h0);
		// data writes stall while the previous word is pending
		for (int i = 0; i < N_WORDS; i++)
			av_xfer(1'b1, REG_DATA, base ^ 32'(i * 32'h01010100), rd);
		for (int n = 0; n < 5000 && u_pcl_link_if.load_complete !== 1'b1; n++)
			@(posedge ref_clk_in);
		chk_val({31'h0, u_pcl_link_if.load_complete}, 32'h1);
		chk_val({31'h0, init_done_out}, {31'h0, !base[0]});
		t = 0;
		while (t < 5000 && user_mode_out !== 1'b1) begin
			@(posedge ref_clk_in);
			t++;
		end
		chk_val({31'h0, user_mode_out}, 32'h1);
		chk_val({31'h0, t >= min_cyc}, 32'h1);
		chk_val({31'h0, init_done_out}, 32'h1);
		chk_val(32'(got_q.size()), 32'(N_WORDS));
		for (int i = 0; i < N_WORDS; i++)
			chk_val(got_q[i], (base ^ 32'(i * 32'h01010100)) & mask);
		repeat (40) @(posedge ref_clk_in);
		chk_val(32'(got_q.size()), 32'(N_WORDS));
		$display("test load done, width %0d", w);
	endtask

	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk_in = 1'b0;
		forever #4 ref_clk_in = ~ref_clk_in;
	end
	initial begin
		user_init_clock_in = 1'b0;
		forever #62.5 user_init_clock_in = ~user_init_clock_in;
	end
	initial begin
		repeat (60000) @(posedge ref_clk_in);
		n_fail++;
		tally_and_finish();
	end
	initial begin
		n_fail = 0;
		checks_done = 0;
		rst_in = 1'b1;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		width_in = PCL_W32;
		decomp_in = 1'b0;
		sec_in = 1'b0;
		init_src_in = PCL_INIT_OSC;
		repeat (20) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		t_reset();
		t_load(1'b0, 1'b0, PCL_W8, PCL_INIT_OSC, 32'hA5C31E01, 40);
		t_load(1'b0, 1'b1, PCL_W16, PCL_INIT_USER, 32'h5A3CE170, 200);
		t_load(1'b1, 1'b1, PCL_W32, PCL_INIT_CFGCLK, 32'hC0DEF00D, 0);
		t_load(1'b1, 1'b0, PCL_W32, PCL_INIT_OSC, 32'h12345670, 40);
		tally_and_finish();
	end
endmodule
